// file: src/ssr_channel.sv
/*
  ssr_channel: clock-synchronous serial receive/transmit channel with
  bit rate generator, polarity, bit order, dual clock pin, continuous
  receive and data inversion options, and an 8-word receive fifo.
  assumes all pin inputs are synchronous to core_clk; the external
  clock pin is sampled and its edges detected in core_clk.
*/
// Overview of operation
// - buffer-to-shifter move sets the transmit buffer empty flag
// - one receive bit is shifted in per transfer clock cycle
// - completed character into receive buffer sets complete flag and request
// - request bit clears on interrupt acceptance or software write of zero
// - clock polarity bit 6 chooses the shifting clock edge
// - bit order bit 7: zero lsb first, one msb first, both directions
// - channel 1 bits 4 and 5 enable two clock pins and pick one
// - dual clock pin output only with internal transfer clock
// - dual clock pin option disables handshake functions
// - continuous receive re-arms reception on receive buffer read
// - channel 2 data logic bit inverts written and read data
// - internal clock period is 2(n+1)/fi
module ssr_channel
  import ssr_pkg::*;
#(
  parameter int unsigned DATA_W = ssr_pkg::SSR_DATA_W,
  parameter int unsigned FIFO_DEPTH = ssr_pkg::SSR_FIFO_DEPTH,
  parameter bit IS_CHANNEL1 = 1'b1,
  parameter bit IS_CHANNEL2 = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // control bits
  input wire logic receive_enable_bit,
  input wire logic transmit_enable_bit,
  input wire logic [7:0] mode_ctrl,
  input wire logic internal_clock_sel,
  input wire logic [1:0] count_source_sel,
  input wire logic [ssr_pkg::SSR_BRG_W-1:0] brg_value,
  input wire logic continuous_rx_en,
  input wire logic data_logic_invert,
  input wire logic handshake_en,
  // transmit buffer write
  input wire logic tx_write,
  input wire logic [ssr_pkg::SSR_DATA_W-1:0] tx_wdata,
  output logic tx_buffer_empty_flag,
  // receive buffer read
  input wire logic rx_read,
  output logic [ssr_pkg::SSR_DATA_W-1:0] rx_rdata,
  output logic receive_complete_flag,
  output logic rx_overflow,
  // interrupt request
  output logic interrupt_request_bit,
  input wire logic irq_accept,
  input wire logic irq_clear_write,
  // serial pins
  input wire logic transfer_clock_in,
  output logic transfer_clock_pin,
  output logic transfer_clock_oe,
  output logic alternate_clock_out_pin,
  output logic alternate_clock_oe,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic request_to_send_out,
  input wire logic clear_to_send_in
);
  import ssr_pkg::*;

  ssr_state_type state, next_state;
  logic [DATA_W-1:0] tx_buf, next_tx_buf, tx_shift, next_tx_shift;
  logic [DATA_W-1:0] rx_shift, next_rx_shift;
  logic tx_full, next_tx_full;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic armed, next_armed;
  logic irq, next_irq;
  logic clk_level, next_clk_level;
  logic [ssr_pkg::SSR_BRG_W-1:0] brg_cnt, next_brg_cnt;
  logic [4:0] pre_cnt, next_pre_cnt;
  logic ext_prev, next_ext_prev;
  logic sdo, next_sdo;
  logic src_tick, brg_tick;
  logic ext_fall, ext_rise, lead_edge, trail_edge;
  logic dual_pin, msb_first, polarity;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;

  function automatic logic [DATA_W-1:0] bit_rev(input logic [DATA_W-1:0] d);
    for (int i = 0; i < DATA_W; i++) begin
      bit_rev[i] = d[DATA_W-1-i];
    end
  endfunction : bit_rev

  function automatic logic [DATA_W-1:0] logic_sw(input logic [DATA_W-1:0] d,
                                                 input logic inv);
    logic_sw = inv ? ~d : d;
  endfunction : logic_sw

  assign polarity = mode_ctrl[SSR_POS_CKPOL];
  assign msb_first = mode_ctrl[SSR_POS_ORDER];
  // dual pin only counts on channel 1 with the internal clock
  assign dual_pin = IS_CHANNEL1 && internal_clock_sel
                    && mode_ctrl[SSR_POS_CLK_EN];

  // count source prescaler f1 / f8 / f32
  always_comb begin
    next_pre_cnt = pre_cnt + 1'b1;
    case (count_source_sel)
      SSR_SRC_F8: src_tick = (pre_cnt >= SSR_PRE_F8);
      SSR_SRC_F32: src_tick = (pre_cnt >= SSR_PRE_F32);
      default: src_tick = 1'b1;
    endcase
    if (src_tick) begin
      next_pre_cnt = '0;
    end
  end

  // half period is n+1 source ticks, so full period is 2(n+1)/fi
  always_comb begin
    brg_tick = 1'b0;
    next_brg_cnt = brg_cnt;
    if (state != SSR_SHIFT) begin
      next_brg_cnt = brg_value;
    end else if (src_tick) begin
      if (brg_cnt == '0) begin
        brg_tick = 1'b1;
        next_brg_cnt = brg_value;
      end else begin
        next_brg_cnt = brg_cnt - 1'b1;
      end
    end
  end

  // external clock edges in core_clk; polarity picks which edge shifts
  assign ext_fall = ext_prev && !transfer_clock_in;
  assign ext_rise = !ext_prev && transfer_clock_in;
  always_comb begin
    next_ext_prev = transfer_clock_in;
    next_clk_level = clk_level;
    if (internal_clock_sel) begin
      lead_edge = brg_tick && (clk_level != polarity);
      trail_edge = brg_tick && (clk_level == polarity);
      if (brg_tick) begin
        next_clk_level = !clk_level;
      end
      if (state != SSR_SHIFT) begin
        next_clk_level = !polarity;
      end
    end else begin
      // the peer drives every bit clock here
      lead_edge = polarity ? ext_rise : ext_fall;
      trail_edge = polarity ? ext_fall : ext_rise;
      next_clk_level = !polarity;
    end
  end

  // transfer state
  always_comb begin
    next_state = state;
    next_tx_buf = tx_buf;
    next_tx_full = tx_full;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_bit_cnt = bit_cnt;
    next_armed = armed;
    next_sdo = sdo;
    next_irq = irq;
    fifo_in_valid = 1'b0;
    if (tx_write) begin
      next_tx_buf = logic_sw(tx_wdata, IS_CHANNEL2 && data_logic_invert);
      next_tx_full = 1'b1;
    end
    if (rx_read && continuous_rx_en && receive_enable_bit) begin
      next_armed = 1'b1;
    end
    if (irq_accept || irq_clear_write) begin
      next_irq = 1'b0;
    end
    case (state)
      SSR_IDLE: begin
        // start needs both enables and a loaded buffer or a re-arm
        if (receive_enable_bit && transmit_enable_bit && (tx_full || armed)
            && (!handshake_en || dual_pin || !clear_to_send_in)) begin
          next_tx_shift = msb_first ? bit_rev(tx_buf) : tx_buf;
          next_tx_full = tx_write;
          next_armed = rx_read && continuous_rx_en && receive_enable_bit;
          next_bit_cnt = '0;
          next_sdo = msb_first ? tx_buf[DATA_W-1] : tx_buf[0];
          next_state = SSR_SHIFT;
        end
      end
      SSR_SHIFT: begin
        if (trail_edge) begin
          next_sdo = tx_shift[0];
        end
        if (lead_edge) begin
          // shift in from the top so the first bit ends lsb
          next_rx_shift = {serial_data_in, rx_shift[DATA_W-1:1]};
          next_tx_shift = {1'b0, tx_shift[DATA_W-1:1]};
          next_bit_cnt = bit_cnt + 1'b1;
          if (bit_cnt == SSR_BIT_LAST) begin
            next_state = SSR_DONE;
          end
        end
      end
      SSR_DONE: begin
        fifo_in_valid = 1'b1;
        // a full fifo holds the character here; the link stalls
        if (fifo_in_ready) begin
          next_irq = 1'b1;
          next_state = SSR_IDLE;
        end
      end
      default: next_state = SSR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= SSR_IDLE;
      tx_buf <= SSR_DATA_RESET;
      tx_full <= 1'b0;
      tx_shift <= SSR_DATA_RESET;
      rx_shift <= SSR_DATA_RESET;
      bit_cnt <= '0;
      armed <= 1'b0;
      irq <= 1'b0;
      clk_level <= 1'b1;
      brg_cnt <= SSR_BRG_RESET;
      pre_cnt <= '0;
      ext_prev <= 1'b1;
      sdo <= 1'b1;
    end else begin
      state <= next_state;
      tx_buf <= next_tx_buf;
      tx_full <= next_tx_full;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      bit_cnt <= next_bit_cnt;
      armed <= next_armed;
      irq <= next_irq;
      clk_level <= next_clk_level;
      brg_cnt <= next_brg_cnt;
      pre_cnt <= next_pre_cnt;
      ext_prev <= next_ext_prev;
      sdo <= next_sdo;
    end
  end

  ssr_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(msb_first ? bit_rev(rx_shift) : rx_shift),
    .out_valid(fifo_out_valid),
    .out_ready(rx_read),
    .out_data(fifo_out_data)
  );

  assign tx_buffer_empty_flag = !tx_full;
  assign receive_complete_flag = fifo_out_valid;
  assign rx_rdata = logic_sw(fifo_out_data, IS_CHANNEL2 && data_logic_invert);
  assign rx_overflow = (state == SSR_DONE) && !fifo_in_ready;
  assign interrupt_request_bit = irq;
  assign serial_data_out = sdo;

  // clock pins: choose one of two outputs, the other idles undriven
  always_comb begin
    transfer_clock_pin = clk_level;
    alternate_clock_out_pin = clk_level;
    transfer_clock_oe = internal_clock_sel && !dual_pin;
    alternate_clock_oe = 1'b0;
    if (dual_pin) begin
      transfer_clock_oe = !mode_ctrl[SSR_POS_CLK_SEL];
      alternate_clock_oe = mode_ctrl[SSR_POS_CLK_SEL];
    end
  end

  // ready to receive: low while idle with receive enabled
  assign request_to_send_out = (handshake_en && !dual_pin) ?
                               !(receive_enable_bit && state == SSR_IDLE) : 1'b0;
endmodule : ssr_channel

// file: src/ssr_pkg.sv
/*
  ssr_pkg: constants for the clock-synchronous serial channel.
  assumes a single core_clk domain; all other rates are enables.
*/
package ssr_pkg;
  localparam int unsigned SSR_DATA_W = 8;
  localparam int unsigned SSR_BRG_W = 8;
  localparam int unsigned SSR_FIFO_DEPTH = 8;
  localparam logic [SSR_DATA_W-1:0] SSR_DATA_RESET = 8'h00;
  localparam logic [SSR_BRG_W-1:0] SSR_BRG_RESET = 8'h00;
  localparam logic [2:0] SSR_BIT_LAST = 3'h7;
  // mode control bit positions
  localparam int unsigned SSR_POS_CKPOL = 6;
  localparam int unsigned SSR_POS_ORDER = 7;
  localparam int unsigned SSR_POS_CLK_EN = 4;
  localparam int unsigned SSR_POS_CLK_SEL = 5;
  // count source select codes
  localparam logic [1:0] SSR_SRC_F1 = 2'h0;
  localparam logic [1:0] SSR_SRC_F8 = 2'h1;
  localparam logic [1:0] SSR_SRC_F32 = 2'h2;
  localparam logic [4:0] SSR_PRE_F8 = 5'h07;
  localparam logic [4:0] SSR_PRE_F32 = 5'h1F;
  typedef enum logic [1:0] {SSR_IDLE, SSR_SHIFT, SSR_DONE} ssr_state_type;
endpackage : ssr_pkg

// file: src/ssr_fifo.sv
/*
  ssr_fifo: small synchronous fifo with valid/ready on both sides.
  assumes one clock; full and empty are exact, no bypass path.
*/
module ssr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage carries no reset; the pointers gate what is seen
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : ssr_fifo

// file: sim/ssr_channel_assertions.sv
/*
  ssr_channel_assertions: port-level checks on the serial channel.
  assumes one core_clk domain and async active-low resetn.
*/
module ssr_channel_assertions
  import ssr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // stimulus side
  input wire logic [7:0] mode_ctrl,
  input wire logic [1:0] count_source_sel,
  input wire logic [ssr_pkg::SSR_BRG_W-1:0] brg_value,
  input wire logic tx_write,
  input wire logic rx_read,
  input wire logic irq_accept,
  input wire logic irq_clear_write,
  // observed outputs
  input wire logic tx_buffer_empty_flag,
  input wire logic receive_complete_flag,
  input wire logic interrupt_request_bit,
  input wire logic transfer_clock_pin,
  input wire logic alternate_clock_oe,
  input wire logic request_to_send_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] gap;
  logic [9:0] next_gap;
  logic last_clk;
  logic lead_now;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // leading edges only: the return to idle after a frame is short
  always_comb begin
    lead_now = (last_clk != transfer_clock_pin)
               && (transfer_clock_pin == mode_ctrl[SSR_POS_CKPOL]);
    next_gap = (gap == 10'h3FF) ? gap : gap + 10'h001;
    if (lead_now) begin
      next_gap = 10'h001;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gap <= 10'h3FF;
      last_clk <= 1'b1;
    end else begin
      gap <= next_gap;
      last_clk <= transfer_clock_pin;
    end
  end
  AST_BRG_PERIOD: assert property (
    lead_now && count_source_sel == SSR_SRC_F1 |-> gap >= {brg_value, 1'b0} + 10'h002)
    else $error("transfer clock period too short");
  AST_IRQ_HOLD: assert property (
    interrupt_request_bit && !irq_accept && !irq_clear_write |=> interrupt_request_bit)
    else $error("request bit dropped without a clear");
  AST_IRQ_FALL: assert property (
    $fell(interrupt_request_bit) |-> $past(irq_accept) || $past(irq_clear_write))
    else $error("request bit fell without a clear");
  AST_IRQ_CAUSE: assert property (
    $rose(interrupt_request_bit) |-> receive_complete_flag)
    else $error("request bit rose with nothing received");
  AST_LAND_IRQ: assert property (
    $rose(receive_complete_flag) |-> ##[0:2] interrupt_request_bit)
    else $error("received char raised no request");
  AST_TXE_FALL: assert property (
    $fell(tx_buffer_empty_flag) |-> $past(tx_write))
    else $error("buffer empty flag fell without a write");
  AST_RCF_FALL: assert property (
    $fell(receive_complete_flag) |-> $past(rx_read))
    else $error("complete flag fell without a read");
  AST_DUAL_RTS: assert property (
    mode_ctrl[SSR_POS_CLK_EN] [*2] |-> !request_to_send_out)
    else $error("handshake active with dual clock pins");
  AST_ALT_OE: assert property (
    !mode_ctrl[SSR_POS_CLK_EN] [*2] |-> !alternate_clock_oe)
    else $error("alternate clock pin driven while off");
  cover property ($rose(interrupt_request_bit) && mode_ctrl[SSR_POS_ORDER]);
  cover property (irq_accept && interrupt_request_bit);
  cover property (lead_now && mode_ctrl[SSR_POS_CLK_EN] && mode_ctrl[SSR_POS_CLK_SEL]);
endmodule : ssr_channel_assertions

bind ssr_channel ssr_channel_assertions u_chk (.core_clk, .resetn, .mode_ctrl,
  .count_source_sel, .brg_value, .tx_write, .rx_read, .irq_accept, .irq_clear_write,
  .tx_buffer_empty_flag, .receive_complete_flag, .interrupt_request_bit,
  .transfer_clock_pin, .alternate_clock_oe, .request_to_send_out);

// file: sim/ssr_peer.sv
/*
  ssr_peer: far-end device shifting one armed byte per frame.
  assumes clk_line is the channel's clock when internal, else ext_clk
  from drive; captures the channel's data out on leading edges.
*/
module ssr_peer (
  // link
  input wire logic clk_line,
  input wire logic sdo_line,
  output logic data_line,
  output logic ext_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] frame;
  logic [7:0] got;
  logic pol;
  logic ord;
  int left = 0;
  initial data_line = 1'b1;
  initial ext_clk = 1'b1;
  task automatic load(input logic [7:0] b, input logic msb, input logic ck);
    for (int i = 0; i < 8; i++) begin
      frame[i] = msb ? b[7-i] : b[i];
    end
    pol = ck;
    ord = msb;
    ext_clk = !ck;
    left = 8;
    data_line = frame[0];
  endtask : load
  // sixteen edges from idle; half periods keep to core_clk falls
  task automatic drive(input int half);
    repeat (16) begin
      #(half * 100);
      ext_clk = ~ext_clk;
    end
  endtask : drive
  // within a frame change on trailing edges only, so the leading edge sees a settled bit
  always @(clk_line) begin
    if (left > 0 && clk_line == pol) begin
      left = left - 1;
      got = ord ? {got[6:0], sdo_line} : {sdo_line, got[7:1]};
    end else if (left > 0 && left < 8) begin
      frame = frame >> 1;
      data_line = frame[0];
    end else if (left == 0) begin
      data_line = ~data_line;
    end
  end
endmodule : ssr_peer

// file: sim/tb_top.sv
/*
  tb_top: self-checking bench for ssr_channel with a serial peer.
  assumes either clock source; inputs change on the falling edge, save serial_data_in, which the peer changes on clk_line edges.
*/
module tb_top
  import ssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic resetn, receive_enable_bit, transmit_enable_bit, internal_clock_sel;
  logic continuous_rx_en, data_logic_invert, handshake_en, tx_write, rx_read;
  logic irq_accept, irq_clear_write, transfer_clock_in, serial_data_in, clear_to_send_in;
  logic [7:0] mode_ctrl, tx_wdata, brg_value, rx_rdata;
  logic [1:0] count_source_sel;
  logic tx_buffer_empty_flag, receive_complete_flag, rx_overflow, interrupt_request_bit;
  logic transfer_clock_pin, transfer_clock_oe, alternate_clock_out_pin, alternate_clock_oe;
  logic serial_data_out, request_to_send_out;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] expq[$];
  ssr_channel DUT (.core_clk, .resetn, .receive_enable_bit, .transmit_enable_bit,
    .mode_ctrl, .internal_clock_sel, .count_source_sel, .brg_value, .continuous_rx_en,
    .data_logic_invert, .handshake_en, .tx_write, .tx_wdata, .tx_buffer_empty_flag,
    .rx_read, .rx_rdata, .receive_complete_flag, .rx_overflow, .interrupt_request_bit,
    .irq_accept, .irq_clear_write, .transfer_clock_in, .transfer_clock_pin,
    .transfer_clock_oe, .alternate_clock_out_pin, .alternate_clock_oe, .serial_data_in,
    .serial_data_out, .request_to_send_out, .clear_to_send_in);
  // an undriven clock pin floats to its pull-up level
  ssr_peer u_peer (.clk_line(!internal_clock_sel ? transfer_clock_in :
    alternate_clock_oe ? alternate_clock_out_pin : transfer_clock_oe ? transfer_clock_pin :
    1'b1), .sdo_line(serial_data_out), .data_line(serial_data_in),
    .ext_clk(transfer_clock_in));
  initial forever #50 core_clk = ~core_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // generous ceiling: slowest source and divider on every char
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask : pulse
  // how: 0 dummy write, 1 re-arm by read, 2 write held back by a low enable
  task automatic frame(input logic [7:0] d, input int how);
    @(negedge core_clk);
    mode_ctrl = 8'($urandom) & 8'hF0;
    count_source_sel = 2'($urandom_range(0, 2));
    brg_value = 8'($urandom_range(0, 2));
    internal_clock_sel = ($urandom_range(0, 3) != 0);
    handshake_en = 1'($urandom);
    u_peer.load(d, mode_ctrl[SSR_POS_ORDER], mode_ctrl[SSR_POS_CKPOL]);
    if (how == 1) begin
      check(rx_rdata, expq.pop_front());
      pulse(rx_read);
    end else begin
      transmit_enable_bit = (how == 0);
      tx_wdata = 8'($urandom);
      pulse(tx_write);
      repeat (20) @(negedge core_clk);
      check(tx_buffer_empty_flag, how == 0);
      if (how == 2) check(interrupt_request_bit, 1'b0);
      transmit_enable_bit = 1'b1;
    end
    expq.push_back(d);
    if (!internal_clock_sel) u_peer.drive(int'($urandom_range(1, 4)));
    for (int i = 0; i < 4000 && u_peer.left != 0; i++) @(negedge core_clk);
    repeat (6) @(negedge core_clk);
    check(u_peer.got, tx_wdata);
  endtask : frame
  initial begin
    {resetn, tx_write, rx_read, irq_accept, irq_clear_write, continuous_rx_en} = '0;
    {data_logic_invert, handshake_en, clear_to_send_in, tx_wdata, mode_ctrl} = '0;
    {receive_enable_bit, transmit_enable_bit, internal_clock_sel} = '1;
    {count_source_sel, brg_value} = '0;
    void'($urandom(32'hc29c));
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    check({tx_buffer_empty_flag, receive_complete_flag, interrupt_request_bit}, 3'h4);
    // single chars, both ways of clearing the request
    for (int k = 0; k < 6; k++) begin
      frame(8'($urandom), k == 0 ? 2 : 0);
      check(receive_complete_flag, 1'b1);
      check(interrupt_request_bit, 1'b1);
      check(rx_rdata, expq.pop_front());
      if (k[0]) pulse(irq_accept);
      else pulse(irq_clear_write);
      check(interrupt_request_bit, 1'b0);
      pulse(rx_read);
      check(receive_complete_flag, 1'b0);
    end
    // overfill: the ninth char must wait, not overwrite
    for (int k = 0; k < 9; k++) frame(8'($urandom), 0);
    check(rx_overflow, 1'b1);
    while (expq.size() > 0) begin
      check(rx_rdata, expq.pop_front());
      pulse(rx_read);
      repeat (3) @(negedge core_clk);
    end
    check(receive_complete_flag, 1'b0);
    pulse(irq_clear_write);
    continuous_rx_en = 1'b1;
    frame(8'($urandom), 0);
    for (int k = 0; k < 3; k++) frame(8'($urandom), 1);
    continuous_rx_en = 1'b0;
    check(rx_rdata, expq.pop_front());
    summarize();
  end
endmodule : tb_top
